// >>> rtl/link_config_status_regs.sv
// Purpose: paged link configuration and per-lane deskew and disparity status
// Assumes: lane events come from logic on i_clk; deskew flags are pin-level
// Notes:   one clock domain; the counters saturate at their maximum
`timescale 1ns/1ps
`default_nettype none

module link_config_status_regs
	import link_cfg_pkg::*;
#(
	parameter int LANES = NUM_LANES,
	parameter int LINKS = NUM_LINKS,
	parameter int CNT_W = DATA_W
) (
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	input  wire logic              i_ce,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	input  wire logic [LANES-1:0]  i_deskew_done_lane,
	input  wire logic [LANES-1:0]  i_disparity_err_lane,
	input  wire logic              i_link_sel,
	output logic                   o_lane_deframer_rst,
	output logic                   o_irq
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [DATA_W-1:0]                   page;
		logic [DATA_W-1:0]                   deframer;
		logic [DATA_W-1:0]                   threshold;
		logic [LINKS-1:0][DATA_W-1:0]        spare_one;
		logic [LINKS-1:0][DATA_W-1:0]        spare_two;
		logic [LINKS-1:0][DATA_W-1:0]        checksum;
		logic [LINKS-1:0][LANES-1:0]         deskew;
		logic [LINKS-1:0][LANES-1:0][CNT_W-1:0] err_cnt;
		logic [LINKS-1:0][LANES-1:0]         disp;
		logic [LANES-1:0]                    desk_s1;
		logic [LANES-1:0]                    desk_s2;
		logic [LANES-1:0]                    irq_status;
		logic [LANES-1:0]                    irq_mask;
		logic [DATA_W-1:0]                   rdata;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
		hit = (a == ofs[ADDR_W-1:0]);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic              sel;
	logic              dst;
	logic [LANES-1:0]  disp_rise;
	logic [DATA_W-1:0] rd_val;

	always_comb begin
		nxt_state = state_ff;
		// out-of-range pages alias onto the link picked by page bit 0 rather than vanish
		sel       = state_ff.page[POS_PAGE];
		dst       = i_link_sel;
		disp_rise = '0;
		rd_val    = READ_UNMAPPED;

		// deskew flags cross from the link side through two flops
		nxt_state.desk_s1     = i_deskew_done_lane;
		nxt_state.desk_s2     = state_ff.desk_s1;
		nxt_state.deskew[dst] = state_ff.desk_s2;

		for (int l = 0; l < LANES; l++) begin
			// counter saturates so a long error burst cannot wrap below threshold
			if (state_ff.deframer[POS_DEFRAMER_RST]) begin
				nxt_state.err_cnt[dst][l] = '0;
			end else if (i_disparity_err_lane[l] && (&state_ff.err_cnt[dst][l] == 1'b0)) begin
				nxt_state.err_cnt[dst][l] = state_ff.err_cnt[dst][l] + 1'b1;
			end
			for (int k = 0; k < LINKS; k++) begin
				nxt_state.disp[k][l] = (state_ff.err_cnt[k][l] >= state_ff.threshold);
			end
			disp_rise[l] = nxt_state.disp[dst][l] & ~state_ff.disp[dst][l];
		end

		if (i_wr) begin
			if (hit(i_addr, OFS_LINK_PAGE)) begin
				nxt_state.page = i_wdata;
			end
			if (hit(i_addr, OFS_DEFRAMER_CTRL)) begin
				nxt_state.deframer = i_wdata;
			end
			if (hit(i_addr, OFS_ERR_THRESHOLD)) begin
				nxt_state.threshold = i_wdata;
			end
			if (hit(i_addr, OFS_SPARE_ONE)) begin
				nxt_state.spare_one[sel] = i_wdata;
			end
			if (hit(i_addr, OFS_SPARE_TWO)) begin
				nxt_state.spare_two[sel] = i_wdata;
			end
			// the device stores the checksum whenever written; software owns the timing
			if (hit(i_addr, OFS_CHECKSUM)) begin
				nxt_state.checksum[sel] = i_wdata;
			end
			if (hit(i_addr, OFS_IRQ_MASK)) begin
				nxt_state.irq_mask = i_wdata[LANES-1:0];
			end
			if (hit(i_addr, OFS_IRQ_STATUS)) begin
				nxt_state.irq_status = state_ff.irq_status & ~i_wdata[LANES-1:0];
			end
		end
		// a new crossing set wins over a write-one clear in the same cycle
		nxt_state.irq_status = nxt_state.irq_status | disp_rise;

		unique case (1'b1)
			hit(i_addr, OFS_LINK_PAGE):     rd_val = state_ff.page;
			hit(i_addr, OFS_DEFRAMER_CTRL): rd_val = state_ff.deframer;
			hit(i_addr, OFS_ERR_THRESHOLD): rd_val = state_ff.threshold;
			hit(i_addr, OFS_DENSITY_CTRL): begin
				rd_val[POS_DENSITY] = RST_DENSITY;
				// control bits per sample exist only on link 0 and stay at reset value
				rd_val[CTRL_BITS_W-1:0] = (sel == 1'b0) ? RST_CTRL_BITS : 5'h00;
			end
			hit(i_addr, OFS_SPARE_ONE):     rd_val = state_ff.spare_one[sel];
			hit(i_addr, OFS_SPARE_TWO):     rd_val = state_ff.spare_two[sel];
			hit(i_addr, OFS_CHECKSUM):      rd_val = state_ff.checksum[sel];
			// deskew and disparity status bytes ignore writes because no write path reaches them
			hit(i_addr, OFS_DESKEW_STATUS): rd_val = state_ff.deskew[sel];
			hit(i_addr, OFS_DISP_STATUS):   rd_val = state_ff.disp[sel];
			hit(i_addr, OFS_IRQ_STATUS):    rd_val = state_ff.irq_status;
			hit(i_addr, OFS_IRQ_MASK):      rd_val = state_ff.irq_mask;
			default:                        rd_val = READ_UNMAPPED;
		endcase
		nxt_state.rdata = i_rd ? rd_val : READ_UNMAPPED;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff.page       <= RST_PAGE;
			state_ff.deframer   <= RST_DEFRAMER;
			state_ff.threshold  <= RST_THRESHOLD;
			state_ff.spare_one  <= '0;
			state_ff.spare_two  <= '0;
			state_ff.checksum   <= '0;
			state_ff.deskew     <= '0;
			state_ff.err_cnt    <= '0;
			state_ff.disp       <= '0;
			state_ff.desk_s1    <= '0;
			state_ff.desk_s2    <= '0;
			state_ff.irq_status <= '0;
			state_ff.irq_mask   <= '0;
			state_ff.rdata      <= READ_UNMAPPED;
		end else if (i_ce) begin
			state_ff <= nxt_state;
		end
	end

	assign o_rdata             = state_ff.rdata;
	assign o_lane_deframer_rst = state_ff.deframer[POS_DEFRAMER_RST];
	assign o_irq               = |(state_ff.irq_status & state_ff.irq_mask);

endmodule : link_config_status_regs
`default_nettype wire

// >>> rtl/link_cfg_pkg.sv
// Purpose: constants for the link configuration and lane status register bank
// Assumes: byte-wide registers on a plain strobe port, eight lanes
// Notes:   offsets are register indices as printed, not byte addresses
package link_cfg_pkg;
	localparam int          ADDR_W            = 12;
	localparam int          DATA_W            = 8;
	localparam int          NUM_LANES         = 8;
	localparam int          NUM_LINKS         = 2;
	localparam logic [11:0] OFS_LINK_PAGE     = 12'h300;
	localparam logic [11:0] OFS_DENSITY_CTRL  = 12'h45a;
	localparam logic [11:0] OFS_SPARE_ONE     = 12'h45b;
	localparam logic [11:0] OFS_SPARE_TWO     = 12'h45c;
	localparam logic [11:0] OFS_CHECKSUM      = 12'h45d;
	localparam logic [11:0] OFS_DESKEW_STATUS = 12'h46c;
	localparam logic [11:0] OFS_DISP_STATUS   = 12'h46d;
	localparam logic [11:0] OFS_DEFRAMER_CTRL = 12'h475;
	localparam logic [11:0] OFS_ERR_THRESHOLD = 12'h4f0;
	localparam logic [11:0] OFS_IRQ_STATUS    = 12'h4f1;
	localparam logic [11:0] OFS_IRQ_MASK      = 12'h4f2;
	localparam int          POS_DENSITY       = 7;
	localparam int          CTRL_BITS_W       = 5;
	localparam int          POS_DEFRAMER_RST  = 3;
	localparam int          POS_PAGE          = 0;
	localparam logic        RST_DENSITY       = 1'b1;
	localparam logic [4:0]  RST_CTRL_BITS     = 5'h00;
	localparam logic [7:0]  RST_SPARE         = 8'h00;
	localparam logic [7:0]  RST_CHECKSUM      = 8'h00;
	localparam logic [7:0]  RST_STATUS        = 8'h00;
	localparam logic [7:0]  RST_THRESHOLD     = 8'hff;
	localparam logic [7:0]  RST_DEFRAMER      = 8'h00;
	localparam logic [7:0]  RST_PAGE          = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED     = 8'h00;
endpackage : link_cfg_pkg

// >>> verif/link_cfg_asserts.sv
// Purpose: port-level checks of the link register bank
// Assumes: i_ce held high by the bench
// Notes:   a deskew bit may only read one for a lane that was ever high
`timescale 1ns/1ps
`default_nettype none
module link_cfg_asserts
	import link_cfg_pkg::*;
#(parameter int LANES = NUM_LANES) (
	input  wire logic              i_clk,
	input  wire logic              i_resetn,
	input  wire logic              i_ce,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	input  wire logic [DATA_W-1:0] o_rdata,
	input  wire logic [LANES-1:0]  i_deskew_done_lane
);
	logic [LANES-1:0] ever_ff;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) ever_ff <= '0;
		else ever_ff <= ever_ff | i_deskew_done_lane;
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	AST_DENSITY_READ: assert property (i_rd && i_ce && i_addr == OFS_DENSITY_CTRL
		|=> o_rdata == 8'h80) else $error("density byte wrong");
	AST_RO_IGNORED: assert property (i_wr && i_addr == OFS_DENSITY_CTRL ##1 !i_wr ##1 i_rd &&
		i_addr == OFS_DENSITY_CTRL |=> o_rdata == 8'h80) else $error("read-only byte changed");
	AST_SPARE_ONE_RW: assert property (i_wr && i_addr == OFS_SPARE_ONE ##1 !i_wr ##1 i_rd &&
		i_addr == OFS_SPARE_ONE |=> o_rdata == $past(i_wdata, 3)) else $error("spare one lost");
	AST_SPARE_TWO_RW: assert property (i_wr && i_addr == OFS_SPARE_TWO ##1 !i_wr ##1 i_rd &&
		i_addr == OFS_SPARE_TWO |=> o_rdata == $past(i_wdata, 3)) else $error("spare two lost");
	AST_CHECKSUM_RW: assert property (i_wr && i_addr == OFS_CHECKSUM ##1 !i_wr ##1 i_rd &&
		i_addr == OFS_CHECKSUM |=> o_rdata == $past(i_wdata, 3)) else $error("checksum lost");
	AST_DESKEW_CAUSE: assert property (i_rd && i_ce && i_addr == OFS_DESKEW_STATUS
		|=> (o_rdata & ~ever_ff) == 8'h00) else $error("deskew bit without cause");
	AST_RDATA_IDLE: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
		else $error("read data outside read");
endmodule : link_cfg_asserts
bind link_config_status_regs link_cfg_asserts #(.LANES(LANES)) u_asserts (.i_clk, .i_resetn,
	.i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_deskew_done_lane);
`default_nettype wire

// >>> verif/lane_source.sv
// Purpose: far-end lane source: deskew flags and disparity error pulses
// Assumes: lane traffic runs on the register clock
// Notes:   link select is held between calls so counts land in one link
`timescale 1ns/1ps
`default_nettype none
module lane_source (
	input  wire logic       i_clk,
	output logic      [7:0] o_deskew_done_lane,
	output logic      [7:0] o_disparity_err_lane,
	output logic            o_link_sel
);
	initial begin
		o_deskew_done_lane = 8'h00;
		o_disparity_err_lane = 8'h00;
		o_link_sel = 1'b0;
	end
	task automatic send_errors(input int n, input logic [7:0] lanes, input logic link);
		o_link_sel <= link;
		repeat (n) begin
			o_disparity_err_lane <= lanes;
			@(posedge i_clk);
		end
		o_disparity_err_lane <= 8'h00;
		repeat (3) @(posedge i_clk);
	endtask : send_errors
	task automatic set_deskew(input logic [7:0] lanes, input logic link);
		o_link_sel <= link;
		o_deskew_done_lane <= lanes;
		repeat (5) @(posedge i_clk);
	endtask : set_deskew
endmodule : lane_source
`default_nettype wire

// >>> verif/testbench.sv
// Purpose: self-checking bench for the link register bank
// Assumes: 200 MHz clock, fixed seed, i_ce held high
// Notes:   lane traffic comes from lane_source
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import link_cfg_pkg::*;
	logic        clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, irq, dfr_rst, link_sel;
	logic [11:0] addr = 12'h000;
	logic [7:0]  wdata = 8'h00, rdata, deskew, disp, m, v, sp [2];
	logic [11:0] ofs [6] = '{OFS_SPARE_ONE, OFS_SPARE_TWO, OFS_CHECKSUM, OFS_DESKEW_STATUS,
		OFS_DISP_STATUS, 12'h7ff};
	int          failures = 0, num_checks = 0, thr;
	always #2.5 clk = ~clk;
	link_config_status_regs u_dut (.i_clk(clk), .i_resetn(resetn), .i_ce(1'b1), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_deskew_done_lane(deskew),
		.i_disparity_err_lane(disp), .i_link_sel(link_sel), .o_lane_deframer_rst(dfr_rst),
		.o_irq(irq));
	lane_source u_src (.i_clk(clk), .o_deskew_done_lane(deskew), .o_disparity_err_lane(disp),
		.o_link_sel(link_sel));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_disp(input int n, input int t, input logic [7:0] l);
		return (n >= t) ? l : 8'h00;
	endfunction : exp_disp
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	// one idle cycle after each access keeps strobes from being driven twice in a step
	task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, e);
		@(posedge clk);
	endtask : rd_reg
	task automatic chk_pin(input logic b, input logic e);
		#1 check({7'h00, b}, {7'h00, e});
		@(posedge clk);
	endtask : chk_pin
	task automatic report_and_stop;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial begin
		void'($urandom(19395));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		foreach (ofs[i]) rd_reg(ofs[i], 8'h00);
		for (int i = 3; i < 6; i++) wr_reg(ofs[i], 8'($urandom));
		rd_reg(OFS_DISP_STATUS, 8'h00);
		wr_reg(OFS_DENSITY_CTRL, 8'($urandom));
		rd_reg(OFS_DENSITY_CTRL, 8'h80);
		for (int p = 0; p < 2; p++) begin
			sp[p] = 8'($urandom);
			wr_reg(OFS_LINK_PAGE, 8'(p));
			wr_reg(OFS_SPARE_ONE, sp[p]);
			rd_reg(OFS_SPARE_ONE, sp[p]);
			wr_reg(OFS_SPARE_TWO, ~sp[p]);
			rd_reg(OFS_SPARE_TWO, ~sp[p]);
		end
		wr_reg(OFS_LINK_PAGE, 8'h00);
		rd_reg(OFS_SPARE_ONE, sp[0]);
		rd_reg(OFS_DESKEW_STATUS, 8'h00);
		wr_reg(OFS_DEFRAMER_CTRL, 8'h08);
		chk_pin(dfr_rst, 1'b1);
		wr_reg(OFS_CHECKSUM, sp[1]);
		rd_reg(OFS_CHECKSUM, sp[1]);
		wr_reg(OFS_DEFRAMER_CTRL, 8'h00);
		thr = 2 + $urandom % 3;
		m = 8'($urandom) | 8'h01;
		wr_reg(OFS_ERR_THRESHOLD, 8'(thr));
		u_src.send_errors(thr - 1, m, 1'b0);
		rd_reg(OFS_DISP_STATUS, exp_disp(thr - 1, thr, m));
		u_src.send_errors(1, m, 1'b0);
		rd_reg(OFS_DISP_STATUS, exp_disp(thr, thr, m));
		chk_pin(irq, 1'b0);
		wr_reg(OFS_IRQ_MASK, 8'hff);
		chk_pin(irq, 1'b1);
		wr_reg(OFS_IRQ_STATUS, 8'hff);
		chk_pin(irq, 1'b0);
		v = 8'($urandom);
		u_src.set_deskew(v, 1'b1);
		wr_reg(OFS_LINK_PAGE, 8'h01);
		rd_reg(OFS_DESKEW_STATUS, v);
		rd_reg(OFS_DISP_STATUS, 8'h00);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
